/* File: design/sepf_map.svh */
// Constants for the serial-memory pin front end.
// Assumes inclusion by bare name from design and bench files.
`ifndef SEPF_MAP_SVH
`define SEPF_MAP_SVH
`define SEPF_BYTE_W 8
`define SEPF_BIT_TOP 3'h7
`define SEPF_BIT_ZERO 3'h0
`define SEPF_CMD_LATCH_SET 8'h06
`define SEPF_CMD_LATCH_CLEAR 8'h04
`define SEPF_CMD_WRITE 8'h02
`define SEPF_CMD_READ 8'h03
`define SEPF_WRITE_TIME_NS 5000000
`define SEPF_CLK_PERIOD_NS 8
`endif

/* File: design/sepf_pkg.sv */
// Types shared by the serial-memory pin front end.
// Assumes the constants header is compiled alongside.
package sepf_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic is_addr;
    } sepf_word_t;
    typedef enum logic [2:0] {
        SEPF_IDLE, SEPF_CMD, SEPF_ADDR, SEPF_WDATA, SEPF_RDATA, SEPF_DISCARD
    } sepf_phase_t;
endpackage

/* File: design/sepf_buf2.sv */
// Two-entry valid/ready buffer carrying received words.
// Assumes one clock, active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module sepf_buf2
    import sepf_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire sepf_word_t in_word,
    output logic out_valid,
    input wire logic out_ready,
    output sepf_word_t out_word
);
    sepf_word_t mem [2];
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_word = mem[rd_ptr];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (ce) begin
            if (flush) begin
                count <= 2'h0;
                rd_ptr <= 1'b0;
                wr_ptr <= 1'b0;
            end else begin
                if (push) begin
                    mem[wr_ptr] <= in_word;
                    wr_ptr <= ~wr_ptr;
                end
                if (pop) begin
                    rd_ptr <= ~rd_ptr;
                end
                count <= count + {1'b0, push} - {1'b0, pop};
            end
        end
    end
    a_buf_no_overflow: assert property (@(posedge clk) disable iff (!nrst)
        count <= 2'h2) else $error("buffer count overflow");
endmodule
`default_nettype wire

/* File: design/sepf_edge.sv */
// Synchronous edge detector for one sampled pin.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module sepf_edge (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic pin,
    input wire logic idle_level,
    output logic level,
    output logic rise,
    output logic fall
);
    logic prev;
    logic started;
    assign level = prev;
    // No edges until one real sample is held: a pin already low at reset is no fall
    assign rise = started && pin && !prev;
    assign fall = started && !pin && prev;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b1;
            started <= 1'b0;
        end else if (ce) begin
            prev <= started ? pin : idle_level;
            started <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: design/sepf_frontend.sv */
// Serial-port front end: shifts, select handling, write protection.
// Assumes pins synchronous to SYS_CLK; memory core sits behind the word ports.
`timescale 1ns/1ns
`default_nettype none
`include "sepf_map.svh"
module sepf_frontend
    import sepf_pkg::*;
#(
    parameter int WRITE_CYCLES = `SEPF_WRITE_TIME_NS / `SEPF_CLK_PERIOD_NS
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic SEL_N_KICK,
    input wire logic SCK,
    input wire logic SI,
    input wire logic WP_N,
    output logic SO_OUT,
    output logic SO_OE,
    output logic STANDBY,
    output logic WRITE_BUSY,
    output logic LATCH_EN,
    output logic WORD_VALID,
    input wire logic WORD_READY,
    output logic [7:0] WORD_DATA,
    output logic WORD_IS_ADDR,
    output logic COMMIT,
    output logic [7:0] CMD_OUT,
    input wire logic [7:0] RD_DATA
);
    function automatic logic is_write_cmd(input logic [7:0] c);
        return c == `SEPF_CMD_WRITE;
    endfunction

    logic sel_lvl, sel_rise, sel_fall;
    logic sck_lvl, sck_rise, sck_fall;
    logic wp_lvl, wp_rise, wp_fall;
    sepf_edge u_sel (.clk(SYS_CLK), .nrst(NRST), .ce(CE), .pin(SEL_N_KICK),
        .idle_level(SEL_N_KICK), .level(sel_lvl), .rise(sel_rise), .fall(sel_fall));
    sepf_edge u_sck (.clk(SYS_CLK), .nrst(NRST), .ce(CE), .pin(SCK),
        .idle_level(SCK), .level(sck_lvl), .rise(sck_rise), .fall(sck_fall));
    sepf_edge u_wp (.clk(SYS_CLK), .nrst(NRST), .ce(CE), .pin(WP_N),
        .idle_level(WP_N), .level(wp_lvl), .rise(wp_rise), .fall(wp_fall));

    sepf_phase_t phase, next_phase;
    logic armed;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] cmd;
    logic [7:0] tx;
    logic write_pending;
    logic write_abort;
    logic [31:0] busy_cnt;
    logic push_valid;
    sepf_word_t push_word;
    logic buf_ready;
    sepf_word_t out_word;
    logic out_valid;

    wire selected = !SEL_N_KICK;
    wire active = selected && armed && (phase != SEPF_DISCARD);
    wire byte_done = active && sck_rise && (bitcnt == `SEPF_BIT_ZERO);
    // First fall of a byte sends the fresh byte's MSB straight from the core
    wire byte_start = (bitcnt == `SEPF_BIT_TOP);
    wire [7:0] rx_byte = {shreg[6:0], SI};
    wire is_set = rx_byte == `SEPF_CMD_LATCH_SET;
    wire is_clear = rx_byte == `SEPF_CMD_LATCH_CLEAR;
    // Write may start only with latch set, protect high, no abort seen
    wire commit_now = sel_rise && write_pending && !write_abort && WP_N
        && !WRITE_BUSY;
    // Byte met by a full buffer is dropped; in write data the frame then goes to discard, an address byte is lost silently
    wire data_byte = byte_done && (phase == SEPF_ADDR || phase == SEPF_WDATA);

    always_comb begin
        next_phase = phase;
        if (!selected) begin
            next_phase = SEPF_IDLE;
        end else if (byte_done) begin
            unique case (phase)
                SEPF_IDLE, SEPF_CMD: begin
                    if (is_write_cmd(rx_byte) || rx_byte == `SEPF_CMD_READ) begin
                        next_phase = SEPF_ADDR;
                    end else begin
                        next_phase = SEPF_DISCARD;
                    end
                end
                SEPF_ADDR: next_phase = is_write_cmd(cmd) ? SEPF_WDATA : SEPF_RDATA;
                SEPF_WDATA: next_phase = buf_ready ? SEPF_WDATA : SEPF_DISCARD;
                SEPF_RDATA: next_phase = SEPF_RDATA;
                SEPF_DISCARD: next_phase = SEPF_DISCARD;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            armed <= 1'b0;
            phase <= SEPF_IDLE;
            shreg <= 8'h00;
            bitcnt <= `SEPF_BIT_TOP;
            cmd <= 8'h00;
        end else if (CE) begin
            if (sel_fall) begin
                armed <= 1'b1;
            end
            phase <= next_phase;
            if (!selected) begin
                bitcnt <= `SEPF_BIT_TOP;
                shreg <= 8'h00;
            end else if (active && sck_rise) begin
                shreg <= rx_byte;
                bitcnt <= bitcnt - 3'h1;
            end
            if (byte_done && (phase == SEPF_IDLE || phase == SEPF_CMD)) begin
                cmd <= rx_byte;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            LATCH_EN <= 1'b0;
            write_pending <= 1'b0;
            write_abort <= 1'b0;
        end else if (CE) begin
            if (byte_done && phase == SEPF_IDLE && is_set) begin
                LATCH_EN <= 1'b1;
            end else if (byte_done && phase == SEPF_IDLE && is_clear) begin
                LATCH_EN <= 1'b0;
            end else if (commit_now) begin
                LATCH_EN <= 1'b0;
            end
            if (!selected) begin
                write_pending <= 1'b0;
                write_abort <= 1'b0;
            end else begin
                if (byte_done && phase == SEPF_WDATA && LATCH_EN && WP_N) begin
                    write_pending <= 1'b1;
                end
                if (wp_fall && (phase == SEPF_ADDR || phase == SEPF_WDATA)) begin
                    write_abort <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            WRITE_BUSY <= 1'b0;
            busy_cnt <= 32'h0;
            COMMIT <= 1'b0;
        end else if (CE) begin
            COMMIT <= commit_now;
            if (commit_now) begin
                WRITE_BUSY <= 1'b1;
                busy_cnt <= WRITE_CYCLES[31:0];
            end else if (WRITE_BUSY) begin
                // Protect edges ignored here once running
                busy_cnt <= busy_cnt - 32'h1;
                WRITE_BUSY <= busy_cnt != 32'h1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            tx <= 8'h00;
            SO_OUT <= 1'b0;
            SO_OE <= 1'b0;
            STANDBY <= 1'b1;
            CMD_OUT <= 8'h00;
        end else if (CE) begin
            SO_OE <= selected && armed && phase == SEPF_RDATA;
            STANDBY <= !selected && !WRITE_BUSY && !commit_now;
            CMD_OUT <= cmd;
            if (byte_done && phase == SEPF_ADDR) begin
                tx <= RD_DATA;
            end else if (phase == SEPF_RDATA && sck_fall && selected) begin
                SO_OUT <= byte_start ? RD_DATA[7] : tx[7];
                tx <= byte_start ? {RD_DATA[6:0], 1'b0} : {tx[6:0], 1'b0};
            end
        end
    end

    assign push_valid = data_byte;
    assign push_word = '{data: rx_byte, is_addr: (phase == SEPF_ADDR)};

    sepf_buf2 u_buf (.clk(SYS_CLK), .nrst(NRST), .ce(CE), .flush(1'b0),
        .in_valid(push_valid), .in_ready(buf_ready), .in_word(push_word),
        .out_valid(out_valid), .out_ready(WORD_READY && WORD_VALID || !WORD_VALID),
        .out_word(out_word));

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            WORD_VALID <= 1'b0;
            WORD_DATA <= 8'h00;
            WORD_IS_ADDR <= 1'b0;
        end else if (CE) begin
            if (!WORD_VALID || WORD_READY) begin
                WORD_VALID <= out_valid;
                WORD_DATA <= out_word.data;
                WORD_IS_ADDR <= out_word.is_addr;
            end
        end
    end

    a_arm_before_cmd: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !armed |-> phase == SEPF_IDLE || phase == SEPF_DISCARD)
        else $error("decoding before first select fall");
    a_so_hiz_desel: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && SEL_N_KICK |=> !SO_OE)
        else $error("output driven while deselected");
    a_standby_busy: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        WRITE_BUSY |-> !STANDBY)
        else $error("standby during write cycle");
    a_active_sel: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && !SEL_N_KICK |=> !STANDBY)
        else $error("standby while selected");
    a_no_commit_wp: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        commit_now |-> WP_N && !write_abort)
        else $error("write started while protected");
    a_abort_wp: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && write_abort && selected |=> !commit_now)
        else $error("aborted write committed");
    a_busy_holds: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && WRITE_BUSY && busy_cnt > 32'h1 |=> WRITE_BUSY)
        else $error("write cycle cut short");
    a_discard_desel: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && !selected |=> bitcnt == `SEPF_BIT_TOP)
        else $error("partial byte kept");
    a_so_on_fall: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CE && $changed(SO_OUT) |-> $past(sck_fall))
        else $error("output changed off falling edge");
    c_write_commit: cover property (@(posedge SYS_CLK) disable iff (!NRST) COMMIT);
    c_read_drive: cover property (@(posedge SYS_CLK) disable iff (!NRST) SO_OE);
    c_abort: cover property (@(posedge SYS_CLK) disable iff (!NRST) write_abort);
    c_latch_set: cover property (@(posedge SYS_CLK) disable iff (!NRST) $rose(LATCH_EN));
endmodule
`default_nettype wire

/* File: verification/sepf_host.sv */
// Host master model for the serial-memory front end: select, clock, data.
// Assumes one system clock; the bench picks the half period in cycles.
`timescale 1ns/1ns
`default_nettype none
module sepf_host (
    input wire logic clk,
    output logic sel_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    int half = 4;
    // Select starts low, so the first frame has no falling edge to arm on
    initial begin
        sel_n = 1'b0;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Sends n bits, MSB first; read bits taken just before each rise
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            si = tx[i];
            hold(half);
            rx[i] = so_oe ? so : 1'bx;
            sck = 1'b1;
            hold(half);
            sck = 1'b0;
        end
        // Released data line shows the inverse, never a stale bit
        si = ~si;
    endtask
    task automatic start();
        sel_n = 1'b0;
        hold(half);
    endtask
    task automatic stop();
        hold(half);
        sel_n = 1'b1;
        hold(half);
    endtask
endmodule
`default_nettype wire

/* File: verification/sepf_frontend_bench.sv */
// Self-checking bench for the serial-memory pin front end.
// Assumes the host model drives the serial pins; words checked from a queue.
`timescale 1ns/1ns
`default_nettype none
`include "sepf_map.svh"
module sepf_frontend_bench
    import sepf_pkg::*;
;
    localparam int WCYC = 20;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic sel_n, sck, si, wp_n, so_out, so_oe, standby, write_busy, latch_en;
    logic word_valid, word_ready, word_is_addr, commit, so_prev, ignore_words;
    logic [7:0] word_data, cmd_out, rd_data;
    logic [8:0] exp_q[$];
    int n_mismatch = 0;
    int checks_done = 0;
    int n_commit = 0;
    int busy_len = 0;
    always #4 sys_clk = ~sys_clk;
    sepf_frontend #(.WRITE_CYCLES(WCYC)) i_sepf_frontend (
        .SYS_CLK(sys_clk), .NRST(nrst), .CE(1'b1), .SEL_N_KICK(sel_n), .SCK(sck),
        .SI(si), .WP_N(wp_n), .SO_OUT(so_out), .SO_OE(so_oe), .STANDBY(standby),
        .WRITE_BUSY(write_busy), .LATCH_EN(latch_en), .WORD_VALID(word_valid),
        .WORD_READY(word_ready), .WORD_DATA(word_data), .WORD_IS_ADDR(word_is_addr),
        .COMMIT(commit), .CMD_OUT(cmd_out), .RD_DATA(rd_data)
    );
    sepf_host i_sepf_host (
        .clk(sys_clk), .sel_n(sel_n), .sck(sck), .si(si), .so(so_out), .so_oe(so_oe)
    );
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic frame(input logic [7:0] op, a, d, input int nb, output logic [7:0] rx);
        i_sepf_host.start();
        check(9'(standby), 9'h0);
        i_sepf_host.xfer(op, 8, rx);
        if (nb > 1) i_sepf_host.xfer(a, 8, rx);
        if (nb > 2) i_sepf_host.xfer(d, 8, rx);
        i_sepf_host.stop();
        check(9'(so_oe), 9'h0);
        check(9'(standby), 9'(!write_busy));
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Receiver stalls at random; the buffer must hold words meanwhile
    always @(posedge sys_clk) begin
        #1;
        word_ready = 1'($urandom_range(1));
    end
    always @(posedge sys_clk) begin
        if (word_valid && word_ready && !ignore_words) begin
            if (exp_q.size() == 0) check(9'h1ff, 9'h0);
            else check({word_is_addr, word_data}, exp_q.pop_front());
        end
        if (commit) n_commit++;
        if (write_busy) busy_len++;
        if (sck && so_oe) check(9'(so_out), 9'(so_prev));
        so_prev <= so_out;
    end
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] rx, a, d;
        int base;
        void'($urandom(32'h9d42));
        wp_n = 1'b1;
        word_ready = 1'b1;
        rd_data = 8'h00;
        ignore_words = 1'b0;
        so_prev = 1'b0;
        wait_cycles(10);
        nrst = 1'b1;
        wait_cycles(2);
        // Byte clocked before any select fall must be ignored
        i_sepf_host.xfer(`SEPF_CMD_LATCH_SET, 8, rx);
        i_sepf_host.stop();
        check(9'(latch_en), 9'h0);
        check(9'(standby), 9'h1);
        for (int i = 0; i < 2; i++) begin
            frame(i == 0 ? `SEPF_CMD_LATCH_SET : `SEPF_CMD_LATCH_CLEAR, 0, 0, 1, rx);
            check(9'(latch_en), 9'(i == 0));
        end
        // A partial byte must not shift the next frame's bits
        i_sepf_host.start();
        i_sepf_host.xfer(8'h00, 4, rx);
        i_sepf_host.stop();
        frame(`SEPF_CMD_LATCH_SET, 0, 0, 1, rx);
        check(9'(latch_en), 9'h1);
        a = 8'($urandom);
        d = 8'($urandom);
        exp_q.push_back({1'b1, a});
        exp_q.push_back({1'b0, d});
        busy_len = 0;
        frame(`SEPF_CMD_WRITE, a, d, 3, rx);
        for (int i = 0; i < 50 && n_commit == 0; i++) wait_cycles(1);
        check(9'(n_commit), 9'h1);
        wp_n = 1'b0;
        for (int i = 0; i < 60 && write_busy !== 1'b0; i++) wait_cycles(1);
        check(9'(busy_len), 9'(WCYC));
        check(9'(latch_en), 9'h0);
        check(9'(exp_q.size()), 9'h0);
        // Write protect low: writes refused, reads still served
        ignore_words = 1'b1;
        base = n_commit;
        frame(`SEPF_CMD_LATCH_SET, 0, 0, 1, rx);
        frame(`SEPF_CMD_WRITE, a, d, 3, rx);
        wait_cycles(40);
        check(9'(n_commit), 9'(base));
        check(9'(write_busy), 9'h0);
        rd_data = 8'($urandom);
        frame(`SEPF_CMD_READ, a, 8'h00, 3, rx);
        check(9'(rx), 9'(rd_data));
        // Protect falls between address and data: the write is aborted
        wp_n = 1'b1;
        frame(`SEPF_CMD_LATCH_SET, 0, 0, 1, rx);
        i_sepf_host.start();
        i_sepf_host.xfer(`SEPF_CMD_WRITE, 8, rx);
        i_sepf_host.xfer(a, 8, rx);
        // Protect dips and recovers, so only the abort can stop this write
        wp_n = 1'b0;
        wait_cycles(3);
        wp_n = 1'b1;
        i_sepf_host.xfer(d, 8, rx);
        i_sepf_host.stop();
        wait_cycles(40);
        check(9'(n_commit), 9'(base));
        wp_n = 1'b1;
        wait_cycles(4);
        ignore_words = 1'b0;
        // Slow host read with protect high
        i_sepf_host.half = 8;
        rd_data = 8'($urandom);
        exp_q.push_back({1'b1, d});
        frame(`SEPF_CMD_READ, d, 8'h00, 3, rx);
        check(9'(rx), 9'(rd_data));
        check(9'(exp_q.size()), 9'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
